// ### hdl/ssb_pkg.sv
// Constants, register map and shared types of the servo status and brake sequencer.
// Assumes a single 25 MHz clock and register access through an AXI4-Lite slave.
package ssb_pkg;

  // Clock and millisecond base
  localparam int unsigned CLK_HZ      = 25_000_000;
  localparam int unsigned MS_PER_S    = 1000;
  localparam int unsigned TICK_CYCLES = CLK_HZ / MS_PER_S;

  // Speed comparator hysteresis in RPM
  localparam logic [15:0] HYST_RPM = 16'h000a;

  // Compensation time used when the programmed time is zero, in ms
  localparam logic [15:0] TQ_DEFAULT_MS = 16'h03e8;

  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_MATCH_RANGE = 16'h2435;
  localparam logic [15:0] IDX_REACH_THR   = 16'h2436;
  localparam logic [15:0] IDX_ENGAGE_DLY  = 16'h2437;
  localparam logic [15:0] IDX_RELEASE_DLY = 16'h2438;
  localparam logic [15:0] IDX_ACT_SPEED   = 16'h2439;
  localparam logic [15:0] IDX_ESTOP_SEL   = 16'h2443;
  localparam logic [15:0] IDX_TQ_DUR      = 16'h2448;
  localparam logic [15:0] IDX_TQ_EN       = 16'h2610;
  localparam logic [15:0] IDX_DECEL_TO    = 16'h2614;
  localparam logic [15:0] IDX_STATUS      = 16'h2700;
  localparam logic [15:0] IDX_MASK        = 16'h2701;
  localparam logic [15:0] IDX_LIVE        = 16'h2702;

  // Values after reset
  localparam logic [15:0] RST_MATCH_RANGE = 16'h0032;
  localparam logic [15:0] RST_REACH_THR   = 16'h03e8;
  localparam logic [15:0] RST_ENGAGE_DLY  = 16'h0064;
  localparam logic [15:0] RST_RELEASE_DLY = 16'h0000;
  localparam logic [15:0] RST_ACT_SPEED   = 16'h001e;
  localparam logic [15:0] RST_TQ_DUR      = 16'h0000;
  localparam logic [15:0] RST_DECEL_TO    = 16'h01f4;

  // Status bit positions
  localparam int unsigned ST_REACHED  = 0;
  localparam int unsigned ST_MATCH    = 1;
  localparam int unsigned ST_ESTOP    = 2;
  localparam int unsigned ST_RELEASED = 3;
  localparam int unsigned ST_ENGAGED  = 4;
  localparam int unsigned ST_W        = 5;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Brake and power sequence
  typedef enum logic [2:0] {
    SEQ_OFF     = 3'b000,
    SEQ_RELEASE = 3'b001,
    SEQ_RUN     = 3'b010,
    SEQ_DECEL   = 3'b011,
    SEQ_ENGAGE  = 3'b100
  } ssb_seq_e;

  // Register selected by an address
  typedef enum logic [3:0] {
    REG_NONE, REG_MATCH_RANGE, REG_REACH_THR, REG_ENGAGE_DLY, REG_RELEASE_DLY,
    REG_ACT_SPEED, REG_ESTOP_SEL, REG_TQ_DUR, REG_TQ_EN, REG_DECEL_TO,
    REG_STATUS, REG_MASK, REG_LIVE
  } ssb_reg_e;

  // Software settings
  typedef struct packed {
    logic [15:0] match_range;
    logic [15:0] reach_thr;
    logic [15:0] engage_dly;
    logic [15:0] release_dly;
    logic [15:0] act_speed;
    logic [15:0] tq_dur;
    logic [15:0] decel_to;
    logic        estop_ign;
    logic        tq_en;
  } ssb_cfg_s;

endpackage

// ### hdl/ssb_hyst_cmp.sv
// Speed comparator with a hysteresis band around a threshold.
// Assumes value and threshold come from logic on the same clock.
`timescale 1ns/1ps
module ssb_hyst_cmp
  import ssb_pkg::*;
#(
  parameter bit BELOW = 1'b0
)
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Compared quantities
  input  wire logic [15:0] value,
  input  wire logic [15:0] threshold,
  // Result
  output logic             flag_q
);

  logic [16:0] upper;
  logic [16:0] lower;
  logic        on_c;
  logic        off_c;

  // Band edges, lower edge saturates at zero
  always_comb
  begin
    upper = {1'b0, threshold} + {1'b0, HYST_RPM};
    lower = (threshold > HYST_RPM) ? {1'b0, threshold - HYST_RPM} : 17'h00000;
    if (BELOW)
    begin
      on_c  = {1'b0, value} <= lower;
      off_c = {1'b0, value} > upper;
    end
    else
    begin
      on_c  = {1'b0, value} > upper;
      off_c = {1'b0, value} < lower;
    end
  end

  // Flag holds inside the band
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      flag_q <= 1'b0;
    else if (on_c)
      flag_q <= 1'b1;
    else if (off_c)
      flag_q <= 1'b0;
  end

endmodule

// ### hdl/ssb_top.sv
// Speed status flags, holding brake sequencer, emergency stop and enable torque compensation.
// Assumes speeds arrive as signed RPM on aclk; enable and stop come from pins.
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
module ssb_top
  import ssb_pkg::*;
#(
  parameter int unsigned MS_CYCLES = TICK_CYCLES
)
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write
  input  wire logic [17:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [17:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Speeds and pins
  input  wire logic [15:0] motor_speed,
  input  wire logic [15:0] speed_cmd,
  input  wire logic        servo_enable_cmd,
  input  wire logic        estop_in,
  // Drive outputs
  output logic             speed_reached_flag,
  output logic             speed_match_flag,
  output logic             brake_release_q,
  output logic             motor_power_q,
  output logic             motion_enable_q,
  output logic             forced_stop_q,
  output logic             alarm_q,
  output logic [15:0]      torque_comp_q,
  output logic             irq_q
);

  // Address decode, shared by read and write paths
  function automatic ssb_reg_e reg_sel(input logic [17:0] addr);
    if (addr[1:0] != 2'h0)
      return REG_NONE;
    unique case (addr[17:2])
      IDX_MATCH_RANGE: return REG_MATCH_RANGE;
      IDX_REACH_THR:   return REG_REACH_THR;
      IDX_ENGAGE_DLY:  return REG_ENGAGE_DLY;
      IDX_RELEASE_DLY: return REG_RELEASE_DLY;
      IDX_ACT_SPEED:   return REG_ACT_SPEED;
      IDX_ESTOP_SEL:   return REG_ESTOP_SEL;
      IDX_TQ_DUR:      return REG_TQ_DUR;
      IDX_TQ_EN:       return REG_TQ_EN;
      IDX_DECEL_TO:    return REG_DECEL_TO;
      IDX_STATUS:      return REG_STATUS;
      IDX_MASK:        return REG_MASK;
      IDX_LIVE:        return REG_LIVE;
      default:         return REG_NONE;
    endcase
  endfunction

  // Byte-lane merge into a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
    return {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
  endfunction

  ssb_cfg_s      cfg_q;
  ssb_seq_e      seq_q;
  logic [17:0]   aw_addr_q;
  logic [31:0]   w_data_q;
  logic [3:0]    w_strb_q;
  logic          wr_en;
  ssb_reg_e      wr_sel;
  ssb_reg_e      rd_sel;
  logic [31:0]   rd_mux;
  logic [ST_W-1:0] status_q;
  logic [ST_W-1:0] mask_q;
  logic [ST_W-1:0] ev_set;
  logic [1:0]    en_sync_q;
  logic [1:0]    stop_sync_q;
  logic          en_prev_q;
  logic          stop_prev_q;
  logic          reach_prev_q;
  logic          match_prev_q;
  logic          stop_req;
  logic [15:0]   tick_cnt_q;
  logic          tick_q;
  logic [15:0]   ms_cnt_q;
  logic [15:0]   abs_speed;
  logic [16:0]   diff;
  logic [16:0]   abs_diff;
  logic [15:0]   speed_err;
  logic          slow_c;

  // Pin synchronisers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      en_sync_q   <= 2'h0;
      stop_sync_q <= 2'h0;
    end
    else
    begin
      en_sync_q   <= {en_sync_q[0], servo_enable_cmd};
      stop_sync_q <= {stop_sync_q[0], estop_in};
    end
  end

  // Magnitudes of speed and of speed error
  always_comb
  begin
    abs_speed = motor_speed[15] ? 16'(~motor_speed + 16'h0001) : motor_speed;
    diff      = {speed_cmd[15], speed_cmd} - {motor_speed[15], motor_speed};
    abs_diff  = diff[16] ? 17'(~diff + 17'h00001) : diff;
    speed_err = (abs_diff[16]) ? 16'hffff : abs_diff[15:0];
  end

  ssb_hyst_cmp #(.BELOW(1'b0)) u_reach (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .value     (abs_speed),
    .threshold (cfg_q.reach_thr),
    .flag_q    (speed_reached_flag)
  );

  ssb_hyst_cmp #(.BELOW(1'b1)) u_match (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .value     (speed_err),
    .threshold (cfg_q.match_range),
    .flag_q    (speed_match_flag)
  );

  // Millisecond tick
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tick_cnt_q <= 16'h0000;
      tick_q     <= 1'b0;
    end
    else if (tick_cnt_q == 16'(MS_CYCLES - 1))
    begin
      tick_cnt_q <= 16'h0000;
      tick_q     <= 1'b1;
    end
    else
    begin
      tick_cnt_q <= tick_cnt_q + 16'h0001;
      tick_q     <= 1'b0;
    end
  end

  // Stop request only when the stop input is honoured
  assign stop_req = stop_sync_q[1] & ~cfg_q.estop_ign;
  assign slow_c   = abs_speed < cfg_q.act_speed;

  // Emergency stop and alarm
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      forced_stop_q <= 1'b0;
      alarm_q       <= 1'b0;
    end
    else
    begin
      forced_stop_q <= stop_req;
      if (stop_req)
        alarm_q <= 1'b1;
      else if (!stop_sync_q[1] && !en_sync_q[1])
        alarm_q <= 1'b0;
    end
  end

  // Power and brake sequencer
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      seq_q           <= SEQ_OFF;
      ms_cnt_q        <= 16'h0000;
      brake_release_q <= 1'b0;
      motor_power_q   <= 1'b0;
      motion_enable_q <= 1'b0;
    end
    else
    begin
      if (tick_q)
        ms_cnt_q <= ms_cnt_q + 16'h0001;
      unique case (seq_q)
        SEQ_OFF:
        begin
          ms_cnt_q <= 16'h0000;
          if (en_sync_q[1] && !en_prev_q && !stop_req)
          begin
            // Brake released on the cycle after enable
            seq_q           <= SEQ_RELEASE;
            motor_power_q   <= 1'b1;
            brake_release_q <= 1'b1;
          end
        end
        SEQ_RELEASE:
        begin
          if (!en_sync_q[1] || stop_req)
          begin
            seq_q    <= SEQ_DECEL;
            ms_cnt_q <= 16'h0000;
          end
          // Motion blocked until release delay ends
          else if (ms_cnt_q > cfg_q.release_dly)
          begin
            seq_q           <= SEQ_RUN;
            motion_enable_q <= 1'b1;
          end
        end
        SEQ_RUN:
        begin
          if (!en_sync_q[1] || stop_req)
          begin
            seq_q           <= SEQ_DECEL;
            ms_cnt_q        <= 16'h0000;
            motion_enable_q <= 1'b0;
          end
        end
        SEQ_DECEL:
        begin
          // Timeout or low speed ends deceleration
          if (ms_cnt_q > cfg_q.decel_to || slow_c)
          begin
            seq_q         <= SEQ_ENGAGE;
            ms_cnt_q      <= 16'h0000;
            motor_power_q <= 1'b0;
          end
        end
        SEQ_ENGAGE:
        begin
          if (ms_cnt_q > cfg_q.engage_dly)
          begin
            seq_q           <= SEQ_OFF;
            brake_release_q <= 1'b0;
          end
        end
      endcase
    end
  end

  // Torque compensation, remaining ms scale the extra torque
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      torque_comp_q <= 16'h0000;
    else if (seq_q == SEQ_OFF && en_sync_q[1] && !en_prev_q && !stop_req)
    begin
      if (!cfg_q.tq_en)
        torque_comp_q <= 16'h0000;
      else if (cfg_q.tq_dur == 16'h0000)
        torque_comp_q <= TQ_DEFAULT_MS;
      else
        torque_comp_q <= cfg_q.tq_dur;
    end
    else if (tick_q && torque_comp_q != 16'h0000)
      torque_comp_q <= torque_comp_q - 16'h0001;
  end

  // Edge history for events
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      en_prev_q    <= 1'b0;
      stop_prev_q  <= 1'b0;
      reach_prev_q <= 1'b0;
      match_prev_q <= 1'b0;
    end
    else
    begin
      en_prev_q    <= en_sync_q[1];
      stop_prev_q  <= stop_req;
      reach_prev_q <= speed_reached_flag;
      match_prev_q <= speed_match_flag;
    end
  end

  // Event sources
  always_comb
  begin
    ev_set              = '0;
    ev_set[ST_REACHED]  = speed_reached_flag & ~reach_prev_q;
    ev_set[ST_MATCH]    = speed_match_flag & ~match_prev_q;
    ev_set[ST_ESTOP]    = stop_req & ~stop_prev_q;
    ev_set[ST_RELEASED] = (seq_q == SEQ_OFF) && en_sync_q[1] && !en_prev_q && !stop_req;
    ev_set[ST_ENGAGED]  = (seq_q == SEQ_ENGAGE) && (ms_cnt_q > cfg_q.engage_dly);
  end

  // AXI write channels
  assign wr_en  = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wr_sel = reg_sel(aw_addr_q);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      aw_addr_q     <= 18'h00000;
      w_data_q      <= 32'h00000000;
      w_strb_q      <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr_q     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data_q     <= s_axi_wdata;
        w_strb_q     <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_en)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_sel == REG_NONE) ? RESP_DECERR : RESP_OKAY;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Settings registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cfg_q.match_range <= RST_MATCH_RANGE;
      cfg_q.reach_thr   <= RST_REACH_THR;
      cfg_q.engage_dly  <= RST_ENGAGE_DLY;
      cfg_q.release_dly <= RST_RELEASE_DLY;
      cfg_q.act_speed   <= RST_ACT_SPEED;
      cfg_q.tq_dur      <= RST_TQ_DUR;
      cfg_q.decel_to    <= RST_DECEL_TO;
      cfg_q.estop_ign   <= 1'b0;
      cfg_q.tq_en       <= 1'b0;
    end
    else if (wr_en)
    begin
      unique case (wr_sel)
        REG_MATCH_RANGE: cfg_q.match_range <= merge16(cfg_q.match_range, w_data_q, w_strb_q);
        REG_REACH_THR:   cfg_q.reach_thr   <= merge16(cfg_q.reach_thr, w_data_q, w_strb_q);
        REG_ENGAGE_DLY:  cfg_q.engage_dly  <= merge16(cfg_q.engage_dly, w_data_q, w_strb_q);
        REG_RELEASE_DLY: cfg_q.release_dly <= merge16(cfg_q.release_dly, w_data_q, w_strb_q);
        REG_ACT_SPEED:   cfg_q.act_speed   <= merge16(cfg_q.act_speed, w_data_q, w_strb_q);
        REG_TQ_DUR:      cfg_q.tq_dur      <= merge16(cfg_q.tq_dur, w_data_q, w_strb_q);
        REG_DECEL_TO:    cfg_q.decel_to    <= merge16(cfg_q.decel_to, w_data_q, w_strb_q);
        REG_ESTOP_SEL:
        begin
          if (w_strb_q[0])
            cfg_q.estop_ign <= w_data_q[0];
        end
        REG_TQ_EN:
        begin
          if (w_strb_q[0])
            cfg_q.tq_en <= w_data_q[0];
        end
        default:
        begin
        end
      endcase
    end
  end

  // Sticky status with write-one-to-clear, set wins; mask; interrupt
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      status_q <= '0;
      mask_q   <= '0;
      irq_q    <= 1'b0;
    end
    else
    begin
      if (wr_en && wr_sel == REG_STATUS && w_strb_q[0])
        status_q <= (status_q & ~w_data_q[ST_W-1:0]) | ev_set;
      else
        status_q <= status_q | ev_set;
      if (wr_en && wr_sel == REG_MASK && w_strb_q[0])
        mask_q <= w_data_q[ST_W-1:0];
      irq_q <= |(status_q & mask_q);
    end
  end

  // Read data selection
  assign rd_sel = reg_sel(s_axi_araddr);

  always_comb
  begin
    rd_mux = 32'h00000000;
    unique case (rd_sel)
      REG_MATCH_RANGE: rd_mux[15:0] = cfg_q.match_range;
      REG_REACH_THR:   rd_mux[15:0] = cfg_q.reach_thr;
      REG_ENGAGE_DLY:  rd_mux[15:0] = cfg_q.engage_dly;
      REG_RELEASE_DLY: rd_mux[15:0] = cfg_q.release_dly;
      REG_ACT_SPEED:   rd_mux[15:0] = cfg_q.act_speed;
      REG_ESTOP_SEL:   rd_mux[0]    = cfg_q.estop_ign;
      REG_TQ_DUR:      rd_mux[15:0] = cfg_q.tq_dur;
      REG_TQ_EN:       rd_mux[0]    = cfg_q.tq_en;
      REG_DECEL_TO:    rd_mux[15:0] = cfg_q.decel_to;
      REG_STATUS:      rd_mux[ST_W-1:0] = status_q;
      REG_MASK:        rd_mux[ST_W-1:0] = mask_q;
      REG_LIVE:        rd_mux[9:0] = {seq_q, motor_power_q, brake_release_q, motion_enable_q,
                                      forced_stop_q, alarm_q, speed_reached_flag,
                                      speed_match_flag};
      default:         rd_mux = 32'h00000000;
    endcase
  end

  // AXI read channel, answer one cycle after address
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_mux;
      s_axi_rresp   <= (rd_sel == REG_NONE) ? RESP_DECERR : RESP_OKAY;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule

// ### tb/ssb_props.sv
// Port checker for the servo status and brake sequencer.
// Assumes it is bound to ssb_top and watches only its ports.
`timescale 1ns/1ps
module ssb_props
(
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Bus handshakes
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  // Drive outputs
  input wire logic        brake_release_q,
  input wire logic        motor_power_q,
  input wire logic        motion_enable_q,
  input wire logic        forced_stop_q,
  input wire logic        alarm_q,
  input wire logic [15:0] torque_comp_q
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_motion_needs_power;
    motion_enable_q |-> motor_power_q && brake_release_q;
  endproperty
  a_motion_needs_power: assert property (p_motion_needs_power)
    else $error("motion allowed without power or released brake");

  property p_release_with_power;
    $rose(motor_power_q) |-> brake_release_q;
  endproperty
  a_release_with_power: assert property (p_release_with_power)
    else $error("brake not released at power on");

  property p_engage_after_off;
    $fell(brake_release_q) |-> !motor_power_q && $past(!motor_power_q);
  endproperty
  a_engage_after_off: assert property (p_engage_after_off)
    else $error("brake engaged before power was off");

  property p_power_off_first;
    $fell(motor_power_q) |-> brake_release_q && !motion_enable_q;
  endproperty
  a_power_off_first: assert property (p_power_off_first)
    else $error("power removed in the wrong order");

  property p_stop_alarm;
    $rose(forced_stop_q) |-> ##[0:2] alarm_q;
  endproperty
  a_stop_alarm: assert property (p_stop_alarm)
    else $error("forced stop without alarm");

  property p_stop_blocks;
    forced_stop_q |-> ##[0:2] !motion_enable_q;
  endproperty
  a_stop_blocks: assert property (p_stop_blocks)
    else $error("motion still allowed during forced stop");

  property p_comp_decay;
    !$rose(motor_power_q) |-> $past(torque_comp_q) - torque_comp_q <= 16'h0001;
  endproperty
  a_comp_decay: assert property (p_comp_decay)
    else $error("compensation fell by more than one step");

  property p_rd_answer;
    $rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready);
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read answer without a taken address");

  property p_wr_answer;
    $rose(s_axi_bvalid) |-> $past(!s_axi_awready && !s_axi_wready);
  endproperty
  a_wr_answer: assert property (p_wr_answer)
    else $error("write answer before address and data taken");
endmodule

// ### tb/ssb_motor_model.sv
// Behavioural motor: shaft speed ramps toward the command while motion is allowed.
// Assumes the drive's motion enable and speed command on the same clock.
`timescale 1ns/1ps
module ssb_motor_model
#(
  parameter logic [15:0] STEP = 16'h0004
)
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Drive side
  input  wire logic        motion_enable,
  input  wire logic [15:0] speed_cmd,
  input  wire logic        stall,
  // Shaft speed
  output logic      [15:0] motor_speed
);
  logic signed [15:0] tgt;
  logic signed [15:0] dif;

  // Target is zero once motion is withdrawn, so the shaft coasts down
  assign tgt = motion_enable ? speed_cmd : 16'h0000;
  assign dif = tgt - $signed(motor_speed);

  // Limited slew; a stalled load keeps its speed
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      motor_speed <= 16'h0000;
    else if (!stall)
      motor_speed <= (dif > $signed(STEP)) ? motor_speed + STEP :
                     (dif < -$signed(STEP)) ? motor_speed - STEP : tgt;
  end
endmodule

// ### tb/testbench.sv
// Self-checking bench for the servo status and brake sequencer.
// Assumes the motor model on the speed input and a 25 MHz clock.
`timescale 1ns/1ps
module testbench;
  import ssb_pkg::*;
  localparam int MS = 10;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, servo_enable_cmd, estop_in, stall, speed_reached_flag;
  logic        speed_match_flag, brake_release_q, motor_power_q, motion_enable_q;
  logic        forced_stop_q, alarm_q, irq_q;
  logic [17:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [15:0] motor_speed, speed_cmd, torque_comp_q;
  int          bad_count = 0, check_count = 0, cycles = 0, seed, n, thr;
  logic [15:0] idx [7] = '{IDX_MATCH_RANGE, IDX_REACH_THR, IDX_ENGAGE_DLY, IDX_RELEASE_DLY,
                           IDX_ACT_SPEED, IDX_ESTOP_SEL, IDX_TQ_DUR};
  logic [15:0] rst [7] = '{16'h0032, 16'h03e8, 16'h0064, 16'h0000, 16'h001e, 16'h0000, 16'h0000};

  // Design and motor
  ssb_top #(.MS_CYCLES(MS)) uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .motor_speed, .speed_cmd,
    .servo_enable_cmd, .estop_in, .speed_reached_flag, .speed_match_flag, .brake_release_q,
    .motor_power_q, .motion_enable_q, .forced_stop_q, .alarm_q, .torque_comp_q, .irq_q);
  ssb_motor_model mdl (.aclk, .aresetn, .motion_enable(motion_enable_q), .speed_cmd, .stall,
    .motor_speed);

  // Clock
  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  // Hang guard
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      bad_count++;
      summarize();
    end
  end

  task automatic summarize();
    if (bad_count == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic ok(input string nm, input logic c);
    chk(nm, {31'h0, c}, 32'h1);
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge aclk);
  endtask

  // Bus write: address and data offered together, each dropped when taken
  task automatic wr(input logic [15:0] i, input logic [15:0] v);
    logic a, w;
    a = 1'b1;
    w = 1'b1;
    @(posedge aclk);
    s_axi_awaddr <= {i, 2'b00};
    s_axi_wdata <= {16'h0000, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (a || w)
    begin
      @(posedge aclk);
      if (a && s_axi_awready)
      begin
        a = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready)
      begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    chk("bresp", {30'h0, s_axi_bresp}, {30'h0, RESP_OKAY});
    s_axi_bready <= 1'b0;
  endtask

  // Bus read with expected response code
  task automatic rd(input logic [15:0] i, output logic [31:0] v, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= {i, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
    s_axi_rready <= 1'b0;
  endtask

  // Main sequence
  initial
  begin
    seed = 37;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {servo_enable_cmd, estop_in, stall, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    speed_cmd = 16'h0000;
    tick(3);
    aresetn <= 1'b1;
    foreach (idx[k])
    begin
      rd(idx[k], d, RESP_OKAY);
      chk("reset value", d, {16'h0000, rst[k]});
    end
    rd(16'h0001, d, RESP_DECERR);
    chk("unmapped data", d, 32'h0);
    thr = 100 + ($unsigned($random(seed)) % 300);
    wr(IDX_REACH_THR, thr[15:0]);
    rd(IDX_REACH_THR, d, RESP_OKAY);
    chk("threshold", d, {16'h0000, thr[15:0]});
    wr(IDX_RELEASE_DLY, 16'h0003);
    wr(IDX_ENGAGE_DLY, 16'h0002);
    wr(IDX_TQ_EN, 16'h0001);
    wr(IDX_MASK, 16'h001f);
    // Enable, release, compensation and motion
    servo_enable_cmd <= 1'b1;
    for (n = 0; motor_power_q !== 1'b1; n++) tick(1);
    ok("release time", n <= 5 && brake_release_q === 1'b1);
    ok("comp load", torque_comp_q === 16'd1000 || torque_comp_q === 16'd999);
    for (n = 0; motion_enable_q !== 1'b1; n++) tick(1);
    ok("release delay", n >= 3 * MS - 2 && n <= 4 * MS + 2);
    // Speed flags with their hysteresis bands
    speed_cmd <= thr[15:0] + 16'd12;
    tick(150);
    ok("reached on", speed_reached_flag === 1'b1);
    ok("match on", speed_match_flag === 1'b1);
    speed_cmd <= thr[15:0];
    tick(20);
    ok("reached held", speed_reached_flag === 1'b1);
    speed_cmd <= thr[15:0] - 16'd12;
    tick(20);
    ok("reached off", speed_reached_flag === 1'b0);
    speed_cmd <= speed_cmd + 16'd70 + 16'($unsigned($random(seed)) % 100);
    tick(4);
    ok("match off", speed_match_flag === 1'b0);
    tick(80);
    ok("match back", speed_match_flag === 1'b1);
    // Disable: brake ordered at low speed, engaged after the delay
    servo_enable_cmd <= 1'b0;
    for (n = 0; motor_power_q !== 1'b0; n++) tick(1);
    ok("low speed stop", $signed(motor_speed) < 30);
    for (n = 0; brake_release_q !== 1'b0; n++) tick(1);
    ok("engage delay", n >= 2 * MS - 1 && n <= 3 * MS + 2);
    // Stalled load: deceleration ends on the timeout
    wr(IDX_DECEL_TO, 16'h0002);
    servo_enable_cmd <= 1'b1;
    while (motion_enable_q !== 1'b1) tick(1);
    speed_cmd <= 16'd300;
    tick(100);
    stall <= 1'b1;
    servo_enable_cmd <= 1'b0;
    for (n = 0; motor_power_q !== 1'b0; n++) tick(1);
    ok("decel timeout", n >= 2 * MS && n <= 3 * MS + 5);
    ok("still fast", $signed(motor_speed) >= 30);
    stall <= 1'b0;
    while (brake_release_q !== 1'b0) tick(1);
    // Emergency stop honoured, then ignored
    estop_in <= 1'b1;
    tick(6);
    ok("stop honoured", forced_stop_q === 1'b1 && alarm_q === 1'b1);
    estop_in <= 1'b0;
    tick(6);
    ok("alarm cleared", alarm_q === 1'b0);
    wr(IDX_ESTOP_SEL, 16'h0001);
    estop_in <= 1'b1;
    tick(6);
    ok("stop ignored", forced_stop_q === 1'b0 && alarm_q === 1'b0);
    estop_in <= 1'b0;
    // Interrupt: raised, masked, cleared
    rd(IDX_STATUS, d, RESP_OKAY);
    chk("status", d, 32'h1f);
    ok("irq raised", irq_q === 1'b1);
    wr(IDX_MASK, 16'h0000);
    tick(3);
    ok("irq masked", irq_q === 1'b0);
    wr(IDX_MASK, 16'h001f);
    wr(IDX_STATUS, 16'h001f);
    tick(3);
    ok("irq cleared", irq_q === 1'b0);
    summarize();
  end
endmodule

bind ssb_top ssb_props u_props (.aclk, .aresetn, .s_axi_awready, .s_axi_wready, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .brake_release_q, .motor_power_q,
  .motion_enable_q, .forced_stop_q, .alarm_q, .torque_comp_q);
